// ==== hdl/csq_pkg.sv ====
// Package for the calibration pulse sequencer: register map, field layout,
// reset values, timing constants and carrier types.
// Assumes a single 50 MHz clock and an AXI4-Lite register bus.
package csq_pkg;

  localparam int CLK_HZ      = 50_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;
  localparam int N_SEQ       = 2;
  localparam int N_MOD       = 4;
  localparam int N_CH        = 4;
  localparam int N_DIN       = 16;
  localparam int ADDR_W      = 8;

  localparam logic [7:0] INST_STRIDE = 8'h20;
  localparam logic [4:0] OFF_CTRL    = 5'h00;
  localparam logic [4:0] OFF_WIDTH   = 5'h04;
  localparam logic [4:0] OFF_PERIOD  = 5'h08;
  localparam logic [4:0] OFF_TOTAL   = 5'h0c;
  localparam logic [4:0] OFF_STATUS  = 5'h10;
  localparam logic [4:0] OFF_COUNT   = 5'h14;
  localparam logic [4:0] OFF_ROUTE   = 5'h18;

  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_PAUSE_BIT  = 1;
  localparam int CTRL_CLEAR_BIT  = 2;
  localparam int CTRL_EXTEN_BIT  = 3;
  localparam int CTRL_EXTSEL_LSB = 4;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_PROG_LSB   = 8;
  localparam int ROUTE_MODE_LSB  = 0;
  localparam int ROUTE_CHEN_LSB  = 16;

  localparam logic [15:0] RST_WIDTH  = 16'h0005;
  localparam logic [15:0] RST_PERIOD = 16'h000a;
  localparam logic [15:0] RST_TOTAL  = 16'h000a;
  localparam logic [7:0]  PROG_FULL  = 8'hff;
  localparam logic [3:0]  DIV_LAST   = 4'h9;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [15:0]           pulse_width_ms;
    logic [15:0]           pulse_period_ms;
    logic [15:0]           pulse_total;
    logic                  seq_pause_cmd;
    logic                  ext_trigger_en;
    logic [3:0]            ext_trigger_select;
    logic [N_MOD-1:0]      cal_mode;
    logic [N_MOD*N_CH-1:0] chan_en;
  } csq_cfg_t;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  progress;
    logic        active;
  } csq_stat_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} csq_state_t;

endpackage : csq_pkg

// ==== hdl/csq_top.sv ====
// Two independent calibration pulse sequencers behind an AXI4-Lite slave.
// Instance 0 drives direct injector modules, instance 1 port injector modules.
// Assumes one clock, synchronous external trigger inputs, a single master.
`timescale 1ns/1ps

module csq_top #(
  parameter int CYC_PER_MS = csq_pkg::CYC_PER_MS
) (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic [csq_pkg::ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  input  wire logic [csq_pkg::ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  input  wire logic [csq_pkg::N_DIN-1:0]            ext_trig_in,
  output logic [csq_pkg::N_MOD*csq_pkg::N_CH-1:0]   direct_injector_cmd,
  output logic [csq_pkg::N_MOD*csq_pkg::N_CH-1:0]   port_injector_cmd,
  output logic                                      seq_active_flag,
  output logic                                      aux_seq_active_flag,
  output logic [7:0]                                seq_progress,
  output logic [7:0]                                aux_seq_progress
);

  localparam int NCMD = csq_pkg::N_MOD * csq_pkg::N_CH;
  localparam logic [15:0] SUB_LAST = 16'(CYC_PER_MS - 1);

  csq_pkg::csq_cfg_t              cfg_ff       [csq_pkg::N_SEQ];
  csq_pkg::csq_cfg_t              nxt_cfg      [csq_pkg::N_SEQ];
  logic [csq_pkg::N_SEQ-1:0]      start_ff,    nxt_start;
  logic [csq_pkg::N_SEQ-1:0]      clear_ff,    nxt_clear;
  logic                           aw_ok_ff,    nxt_aw_ok;
  logic                           w_ok_ff,     nxt_w_ok;
  logic [csq_pkg::ADDR_W-1:0]     awaddr_ff,   nxt_awaddr;
  logic [31:0]                    wdata_ff,    nxt_wdata;
  logic [3:0]                     wstrb_ff,    nxt_wstrb;
  logic                           bvalid_ff,   nxt_bvalid;
  logic [1:0]                     bresp_ff,    nxt_bresp;
  logic                           rvalid_ff,   nxt_rvalid;
  logic [31:0]                    rdata_ff,    nxt_rdata;
  logic [1:0]                     rresp_ff,    nxt_rresp;
  logic [31:0]                    rd_word;
  logic                           rd_err;
  logic [31:0]                    wr_word;
  logic [31:0]                    old_word;
  logic                           wr_inst;
  wire csq_pkg::csq_stat_t        stat_w       [csq_pkg::N_SEQ];
  wire  [NCMD-1:0]                cmd_w        [csq_pkg::N_SEQ];

  assign s_axi_awready = !aw_ok_ff;
  assign s_axi_wready  = !w_ok_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  function automatic logic [31:0] reg_image(input csq_pkg::csq_cfg_t c, input csq_pkg::csq_stat_t s,
                                            input logic [4:0] off, output logic err);
    logic [31:0] v;
    v   = '0;
    err = 1'b0;
    unique case (off)
      csq_pkg::OFF_CTRL:
      begin
        v[csq_pkg::CTRL_PAUSE_BIT]        = c.seq_pause_cmd;
        v[csq_pkg::CTRL_EXTEN_BIT]        = c.ext_trigger_en;
        v[csq_pkg::CTRL_EXTSEL_LSB +: 4]  = c.ext_trigger_select;
      end
      csq_pkg::OFF_WIDTH:  v[15:0] = c.pulse_width_ms;
      csq_pkg::OFF_PERIOD: v[15:0] = c.pulse_period_ms;
      csq_pkg::OFF_TOTAL:  v[15:0] = c.pulse_total;
      csq_pkg::OFF_STATUS:
      begin
        v[csq_pkg::STAT_ACTIVE_BIT]      = s.active;
        v[csq_pkg::STAT_PROG_LSB +: 8]   = s.progress;
      end
      csq_pkg::OFF_COUNT:  v[15:0] = s.count;
      csq_pkg::OFF_ROUTE:
      begin
        v[csq_pkg::ROUTE_MODE_LSB +: csq_pkg::N_MOD] = c.cal_mode;
        v[csq_pkg::ROUTE_CHEN_LSB +: NCMD]           = c.chan_en;
      end
      default: err = 1'b1;
    endcase
    return v;
  endfunction : reg_image

  // Read decode
  always_comb
  begin
    rd_word = '0;
    rd_err  = 1'b1;
    if (s_axi_araddr[7:6] == 2'b00)
      rd_word = reg_image(cfg_ff[s_axi_araddr[5]], stat_w[s_axi_araddr[5]], s_axi_araddr[4:0], rd_err);
  end

  // Register bus next state
  always_comb
  begin
    nxt_cfg    = cfg_ff;
    nxt_start  = '0;
    nxt_clear  = '0;
    nxt_aw_ok  = aw_ok_ff;
    nxt_w_ok   = w_ok_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    wr_inst    = awaddr_ff[5];
    old_word   = '0;
    wr_word    = '0;
    if (s_axi_awvalid && !aw_ok_ff)
    begin
      nxt_aw_ok  = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ok_ff)
    begin
      nxt_w_ok  = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    // Write waits for both halves and a free response slot
    if (aw_ok_ff && w_ok_ff && !bvalid_ff)
    begin
      nxt_aw_ok  = 1'b0;
      nxt_w_ok   = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = csq_pkg::RESP_OKAY;
      old_word   = reg_image(cfg_ff[wr_inst], stat_w[wr_inst], awaddr_ff[4:0], nxt_bresp[1]);
      for (int b = 0; b < 4; b++)
        wr_word[8*b +: 8] = wstrb_ff[b] ? wdata_ff[8*b +: 8] : old_word[8*b +: 8];
      if (awaddr_ff[7:6] != 2'b00)
        nxt_bresp = csq_pkg::RESP_SLVERR;
      else
        unique case (awaddr_ff[4:0])
          csq_pkg::OFF_CTRL:
          begin
            nxt_start[wr_inst]                     = wr_word[csq_pkg::CTRL_START_BIT];
            nxt_clear[wr_inst]                     = wr_word[csq_pkg::CTRL_CLEAR_BIT];
            nxt_cfg[wr_inst].seq_pause_cmd         = wr_word[csq_pkg::CTRL_PAUSE_BIT];
            nxt_cfg[wr_inst].ext_trigger_en        = wr_word[csq_pkg::CTRL_EXTEN_BIT];
            nxt_cfg[wr_inst].ext_trigger_select    = wr_word[csq_pkg::CTRL_EXTSEL_LSB +: 4];
          end
          csq_pkg::OFF_WIDTH:  nxt_cfg[wr_inst].pulse_width_ms  = wr_word[15:0];
          csq_pkg::OFF_PERIOD: nxt_cfg[wr_inst].pulse_period_ms = wr_word[15:0];
          csq_pkg::OFF_TOTAL:  nxt_cfg[wr_inst].pulse_total     = wr_word[15:0];
          csq_pkg::OFF_ROUTE:
          begin
            nxt_cfg[wr_inst].cal_mode = wr_word[csq_pkg::ROUTE_MODE_LSB +: csq_pkg::N_MOD];
            nxt_cfg[wr_inst].chan_en  = wr_word[csq_pkg::ROUTE_CHEN_LSB +: NCMD];
          end
          default: ;
        endcase
    end
    if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
    if (s_axi_arvalid && !rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_word;
      nxt_rresp  = rd_err ? csq_pkg::RESP_SLVERR : csq_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < csq_pkg::N_SEQ; i++)
      begin
        cfg_ff[i]                 <= '0;
        cfg_ff[i].pulse_width_ms  <= csq_pkg::RST_WIDTH;
        cfg_ff[i].pulse_period_ms <= csq_pkg::RST_PERIOD;
        cfg_ff[i].pulse_total     <= csq_pkg::RST_TOTAL;
      end
      start_ff  <= '0;
      clear_ff  <= '0;
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= csq_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= csq_pkg::RESP_OKAY;
    end
    else
    begin
      cfg_ff    <= nxt_cfg;
      start_ff  <= nxt_start;
      clear_ff  <= nxt_clear;
      aw_ok_ff  <= nxt_aw_ok;
      w_ok_ff   <= nxt_w_ok;
      awaddr_ff <= nxt_awaddr;
      wdata_ff  <= nxt_wdata;
      wstrb_ff  <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  // One sequencer per injector family
  for (genvar g = 0; g < csq_pkg::N_SEQ; g++)
  begin : g_seq
    csq_pkg::csq_state_t state_ff,  nxt_state;
    logic [15:0]         sub_ff,    nxt_sub;
    logic [16:0]         ms_ff,     nxt_ms;
    logic [15:0]         done_ff,   nxt_done;
    logic                trig_ff,   nxt_trig;
    logic                active_ff, nxt_active;
    logic [NCMD-1:0]     cmd_ff,    nxt_cmd;
    logic [16:0]         rem_ff,    nxt_rem;
    logic [7:0]          q_ff,      nxt_q;
    logic [3:0]          step_ff,   nxt_step;
    logic [7:0]          prog_ff,   nxt_prog;
    logic                tick;
    logic [16:0]         ms_inc;
    logic [17:0]         rem2;
    logic                go;
    csq_pkg::csq_cfg_t   c;

    assign c = cfg_ff[g];

    always_comb
    begin
      tick       = (sub_ff == SUB_LAST);
      ms_inc     = ms_ff + 17'(tick);
      nxt_trig   = ext_trig_in[c.ext_trigger_select];
      go         = start_ff[g] || (c.ext_trigger_en && nxt_trig && !trig_ff);
      nxt_state  = state_ff;
      nxt_sub    = tick ? 16'h0000 : sub_ff + 16'h0001;
      nxt_ms     = ms_inc;
      nxt_done   = done_ff;
      unique case (state_ff)
        csq_pkg::ST_IDLE:
        begin
          nxt_sub = 16'h0000;
          nxt_ms  = 17'h00000;
          if (go && c.pulse_total != 16'h0000 && c.pulse_width_ms != 16'h0000)
          begin
            nxt_state = csq_pkg::ST_LOW;
            nxt_ms    = {1'b0, c.pulse_period_ms}; // First pulse due at once
            nxt_done  = 16'h0000;
          end
        end
        csq_pkg::ST_LOW:
        begin
          if (done_ff >= c.pulse_total)
            nxt_state = csq_pkg::ST_IDLE;
          else if (c.seq_pause_cmd)
          begin
            nxt_sub = sub_ff; // Timer frozen, position kept
            nxt_ms  = ms_ff;
          end
          else if (ms_inc >= {1'b0, c.pulse_period_ms})
          begin
            nxt_state = csq_pkg::ST_HIGH;
            nxt_sub   = 16'h0000;
            nxt_ms    = 17'h00000;
            nxt_done  = done_ff + 16'h0001;
          end
        end
        csq_pkg::ST_HIGH:
        begin
          // Pause is not looked at here, so a high pulse always completes
          if (ms_inc >= {1'b0, c.pulse_width_ms})
            nxt_state = (done_ff >= c.pulse_total) ? csq_pkg::ST_IDLE : csq_pkg::ST_LOW;
        end
      endcase
      if (clear_ff[g])
        nxt_done = 16'h0000;
      nxt_active = (nxt_state != csq_pkg::ST_IDLE);
      for (int m = 0; m < csq_pkg::N_MOD; m++)
        for (int ch = 0; ch < csq_pkg::N_CH; ch++)
          nxt_cmd[m*csq_pkg::N_CH + ch] = (nxt_state == csq_pkg::ST_HIGH) && c.cal_mode[m]
            && c.chan_en[m*csq_pkg::N_CH + ch] && $onehot(c.chan_en[m*csq_pkg::N_CH +: csq_pkg::N_CH]);
    end

    // Bit-serial divider; progress lags the count by up to twenty cycles to save a divider array
    always_comb
    begin
      nxt_rem  = rem_ff;
      nxt_q    = q_ff;
      nxt_prog = prog_ff;
      nxt_step = step_ff + 4'h1;
      rem2     = {rem_ff, 1'b0};
      if (step_ff == 4'h0)
      begin
        nxt_rem = {1'b0, done_ff};
        nxt_q   = 8'h00;
      end
      else if (step_ff == csq_pkg::DIV_LAST)
      begin
        nxt_prog = (done_ff >= c.pulse_total) ? csq_pkg::PROG_FULL : q_ff;
        nxt_step = 4'h0;
      end
      else if (rem2 >= {2'b00, c.pulse_total})
      begin
        nxt_rem = 17'(rem2 - {2'b00, c.pulse_total});
        nxt_q   = {q_ff[6:0], 1'b1};
      end
      else
      begin
        nxt_rem = rem2[16:0];
        nxt_q   = {q_ff[6:0], 1'b0};
      end
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        state_ff  <= csq_pkg::ST_IDLE;
        sub_ff    <= '0;
        ms_ff     <= '0;
        done_ff   <= '0;
        trig_ff   <= 1'b0;
        active_ff <= 1'b0;
        cmd_ff    <= '0;
        rem_ff    <= '0;
        q_ff      <= '0;
        step_ff   <= '0;
        prog_ff   <= '0;
      end
      else
      begin
        state_ff  <= nxt_state;
        sub_ff    <= nxt_sub;
        ms_ff     <= nxt_ms;
        done_ff   <= nxt_done;
        trig_ff   <= nxt_trig;
        active_ff <= nxt_active;
        cmd_ff    <= nxt_cmd;
        rem_ff    <= nxt_rem;
        q_ff      <= nxt_q;
        step_ff   <= nxt_step;
        prog_ff   <= nxt_prog;
      end
    end

    assign stat_w[g] = '{count: done_ff, progress: prog_ff, active: active_ff};
    assign cmd_w[g]  = cmd_ff;
  end

  assign direct_injector_cmd = cmd_w[0];
  assign port_injector_cmd   = cmd_w[1];
  assign seq_active_flag     = stat_w[0].active;
  assign aux_seq_active_flag = stat_w[1].active;
  assign seq_progress        = stat_w[0].progress;
  assign aux_seq_progress    = stat_w[1].progress;

endmodule : csq_top

// ==== dv/csq_top_asserts.sv ====
// Concurrent checks on the sequencer top ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps

module csq_top_asserts #(
  parameter int CYC_PER_MS = csq_pkg::CYC_PER_MS
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] direct_injector_cmd,
  input wire logic [15:0] port_injector_cmd,
  input wire logic        seq_active_flag,
  input wire logic        aux_seq_active_flag,
  input wire logic [7:0]  seq_progress
);
  logic [31:0] hi_ff;
  logic [31:0] nxt_hi;

  // High-time counter; merged pulses still land on whole milliseconds
  always_comb nxt_hi = (|direct_injector_cmd) ? hi_ff + 32'h1 : 32'h0;
  always_ff @(posedge aclk) hi_ff <= aresetn ? nxt_hi : 32'h0;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read address not answered");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  b_follow_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##[0:1] s_axi_bvalid)
    else $error("write response late");
  idle_low_a: assert property (!seq_active_flag |-> direct_injector_cmd == 16'h0000)
    else $error("direct pulse while idle");
  aux_idle_low_a: assert property (!aux_seq_active_flag |-> port_injector_cmd == 16'h0000)
    else $error("port pulse while idle");
  one_chan_a: assert property ($onehot0(direct_injector_cmd[3:0]) && $onehot0(direct_injector_cmd[7:4])
    && $onehot0(direct_injector_cmd[11:8]) && $onehot0(direct_injector_cmd[15:12]))
    else $error("several channels of one module driven");
  width_whole_a: assert property ($fell(|direct_injector_cmd) && $past(aresetn)
    |-> hi_ff != 32'h0 && hi_ff % CYC_PER_MS == 0)
    else $error("pulse width not whole milliseconds");
  prog_full_a: assert property ($fell(seq_active_flag) && $past(aresetn) |-> ##[0:30] seq_progress == 8'hff)
    else $error("progress not full at end");

  cover property ($rose(seq_active_flag));
  cover property ($fell(aux_seq_active_flag));
  cover property (s_axi_bvalid && s_axi_bresp == csq_pkg::RESP_SLVERR);
endmodule : csq_top_asserts

bind csq_top csq_top_asserts #(.CYC_PER_MS(CYC_PER_MS)) csq_top_asserts_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .direct_injector_cmd(direct_injector_cmd), .port_injector_cmd(port_injector_cmd),
  .seq_active_flag(seq_active_flag), .aux_seq_active_flag(aux_seq_active_flag), .seq_progress(seq_progress));

// ==== dv/csq_drv_model.sv ====
// Passive model of one bank of injector driver channels.
// Assumes commands are sampled on the rising clock edge.
`timescale 1ns/1ps

module csq_drv_model (
  input  wire logic        aclk,
  input  wire logic        clr,
  input  wire logic [15:0] cmd,
  output logic      [15:0] rises,
  output logic      [15:0] hi_len,
  output logic      [15:0] per_len,
  output logic      [15:0] seen
);
  logic [15:0] prev;
  logic [15:0] hi_cnt;
  logic [15:0] since;

  // Whole-bus timing: every channel that pulses carries the same train
  always @(posedge aclk)
  begin
    prev <= cmd;
    if (clr)
    begin
      rises  <= 16'h0000;
      seen   <= 16'h0000;
      hi_cnt <= 16'h0000;
      since  <= 16'h0000;
    end
    else
    begin
      since <= since + 16'h0001;
      seen  <= seen | cmd;
      if (|cmd)
        hi_cnt <= hi_cnt + 16'h0001;
      if (|cmd && !(|prev))
      begin
        rises   <= rises + 16'h0001;
        per_len <= since;
        since   <= 16'h0001;
      end
      if (!(|cmd) && |prev)
      begin
        hi_len <= hi_cnt;
        hi_cnt <= 16'h0000;
      end
    end
  end
endmodule : csq_drv_model

// ==== dv/test_calibration_pulse_sequencer.sv ====
// Self-checking bench: AXI4-Lite master, trigger lines, two channel models.
// Assumes CYC_PER_MS shortened to 4 so one ms is four cycles.
`timescale 1ns/1ps

module test_calibration_pulse_sequencer;
  localparam int CPM = 4;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mon_clr;
  logic        seq_active_flag, aux_seq_active_flag;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, seq_progress, aux_seq_progress, b;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, w, p, n;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] ext_trig_in, direct_injector_cmd, port_injector_cmd;
  logic [15:0] cmd_bus [2];
  logic [15:0] rises [2];
  logic [15:0] hi_len [2];
  logic [15:0] per_len [2];
  logic [15:0] seen [2];
  int          miscompares, n_checks, c0, c3, sel;

  csq_top #(.CYC_PER_MS(CPM)) csq_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_trig_in(ext_trig_in), .direct_injector_cmd(direct_injector_cmd), .port_injector_cmd(port_injector_cmd),
    .seq_active_flag(seq_active_flag), .aux_seq_active_flag(aux_seq_active_flag),
    .seq_progress(seq_progress), .aux_seq_progress(aux_seq_progress));

  assign cmd_bus[0] = direct_injector_cmd;
  assign cmd_bus[1] = port_injector_cmd;
  for (genvar g = 0; g < 2; g++)
  begin : g_drv
    csq_drv_model csq_drv_model_inst (.aclk(aclk), .clr(mon_clr), .cmd(cmd_bus[g]), .rises(rises[g]),
      .hi_len(hi_len[g]), .per_len(per_len[g]), .seen(seen[g]));
  end

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic logic [7:0] exp_prog(input logic [31:0] c, input logic [31:0] tot);
    return (c >= tot) ? 8'hff : 8'(c * 256 / tot);
  endfunction : exp_prog

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Only the watchdog ends a wait that never gets its answer
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(a[7:6] != 2'b00 ? csq_pkg::RESP_SLVERR : csq_pkg::RESP_OKAY));
  endtask : wr

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, rd);
    chk(rd, e);
  endtask : rchk

  task automatic run_wait(input int s);
    while ((s == 0 ? seq_active_flag : aux_seq_active_flag) !== 1'b0)
    begin
      @(posedge aclk);
    end
    repeat (30) @(posedge aclk);
  endtask : run_wait

  task automatic mon_reset;
    @(posedge aclk);
    mon_clr <= 1'b1;
    @(posedge aclk);
    mon_clr <= 1'b0;
  endtask : mon_reset

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    complete_run();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, mon_clr} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_trig_in} = 64'h0;
    s_axi_wstrb = 4'hf;
    void'($urandom(29748));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      b = 8'(s * 32);
      rchk(b + 8'h04, 32'h5);
      rchk(b + 8'h08, 32'ha);
      rchk(b + 8'h0c, 32'ha);
      rchk(b + 8'h10, 32'h0);
    end
    wr(8'hc0, 32'h1);
    rd_reg(8'h1c, rd);
    chk(rd, 32'h0);
    chk(32'(rsp), 32'(csq_pkg::RESP_SLVERR));
    // Module 1 has two channels, module 2 is outside calibration mode
    for (int s = 0; s < 2; s++)
    begin
      b = 8'(s * 32);
      w = 1 + $urandom % 2;
      p = w + 1 + $urandom % 2;
      n = 2 + $urandom % 3;
      c0 = $urandom % 4;
      c3 = $urandom % 4;
      wr(b + 8'h04, w);
      wr(b + 8'h08, p);
      wr(b + 8'h0c, n);
      wr(b + 8'h18, {4'(1 << c3), 4'(1 << c0), 4'h3, 4'(1 << c0), 12'h000, 4'hb});
      mon_reset();
      wr(b, 32'h1);
      rchk(b + 8'h10, 32'h1);
      run_wait(s);
      chk(32'(s == 0 ? seq_progress : aux_seq_progress), 32'hff);
      chk(32'(rises[s]), n);
      chk(32'(hi_len[s]), w * CPM);
      chk(32'(per_len[s]), p * CPM);
      chk(32'(seen[s]), {16'h0, 4'(1 << c3), 8'h00, 4'(1 << c0)});
      chk(32'(rises[1 - s]), 32'h0);
      rchk(b + 8'h14, n);
      rchk(b + 8'h10, {16'h0, exp_prog(n, n), 8'h00});
    end
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h4);
    wr(8'h0c, 32'h3);
    mon_reset();
    wr(8'h00, 32'h1);
    while (direct_injector_cmd === 16'h0000)
    begin
      @(posedge aclk);
    end
    // Pause lands while the first pulse is still high
    wr(8'h00, 32'h2);
    repeat (60) @(posedge aclk);
    chk(32'(rises[0]), 32'h1);
    chk(32'(hi_len[0]), 32'(2 * CPM));
    chk(32'(seq_active_flag), 32'h1);
    chk(32'(seq_progress), 32'(exp_prog(1, 3)));
    rchk(8'h10, {16'h0, exp_prog(1, 3), 8'h01});
    wr(8'h00, 32'h0);
    run_wait(0);
    chk(32'(rises[0]), 32'h3);
    rchk(8'h14, 32'h3);
    wr(8'h00, 32'h4);
    rchk(8'h14, 32'h0);
    repeat (30) @(posedge aclk);
    rchk(8'h10, {16'h0, exp_prog(0, 3), 8'h00});
    sel = $urandom % 16;
    wr(8'h2c, 32'h2);
    wr(8'h20, 32'(8 + sel * 16));
    mon_reset();
    ext_trig_in <= 16'(1 << (sel ^ 1));
    repeat (20) @(posedge aclk);
    chk(32'(aux_seq_active_flag), 32'h0);
    ext_trig_in <= 16'h0000;
    @(posedge aclk);
    ext_trig_in <= 16'(1 << sel);
    repeat (3) @(posedge aclk);
    chk(32'(aux_seq_active_flag), 32'h1);
    ext_trig_in <= 16'h0000;
    run_wait(1);
    chk(32'(rises[1]), 32'h2);
    complete_run();
  end
endmodule : test_calibration_pulse_sequencer
